// [hw/sdsm_pkg.sv]
// Package for the drive state machine: states, control/status codes, register map.
// Assumes a single 250 MHz control clock; the fieldbus layer presents the control word.
package sdsm_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [15:0] QS_METHOD_OFFSET = 16'h605a;
    localparam logic [15:0] QS_METHOD_RESET  = 16'h0002;
    localparam logic [15:0] QS_METHOD_MAX    = 16'h0007;

    // ------------------------------------------------------------
    // Control word bits and commands
    // ------------------------------------------------------------
    localparam int          CW_QUICK_STOP_BIT = 2;
    localparam int          CW_FAULT_RESET_BIT = 7;
    localparam logic [15:0] CW_CMD_MASK       = 16'h000f;
    localparam logic [15:0] CW_SHUTDOWN       = 16'h0006;
    localparam logic [15:0] CW_SWITCH_ON      = 16'h0007;
    localparam logic [15:0] CW_ENABLE_OP      = 16'h000f;
    localparam logic [15:0] CW_DISABLE        = 16'h0000;
    localparam logic [15:0] CW_QUICK_STOP     = 16'h0002;

    // ------------------------------------------------------------
    // Status word values
    // ------------------------------------------------------------
    localparam logic [15:0] SW_START      = 16'h0000;
    localparam logic [15:0] SW_NO_FAULT   = 16'h0250;
    localparam logic [15:0] SW_READY      = 16'h0231;
    localparam logic [15:0] SW_SWITCHED   = 16'h0233;
    localparam logic [15:0] SW_OP_ENABLED = 16'h0237;
    localparam logic [15:0] SW_QUICK_STOP = 16'h0217;
    localparam logic [15:0] SW_FAULT_REAC = 16'h021f;
    localparam logic [15:0] SW_FAULT      = 16'h0218;

    typedef enum logic [8:0] {
        ST_START    = 9'h001,
        ST_NOT_RDY  = 9'h002,
        ST_SW_DIS   = 9'h004,
        ST_RDY      = 9'h008,
        ST_SW_ON    = 9'h010,
        ST_OP_EN    = 9'h020,
        ST_QSTOP    = 9'h040,
        ST_FLT_REAC = 9'h080,
        ST_FAULT    = 9'h100
    } sdsm_state_t;

    // Parameter write request from the fieldbus side
    typedef struct packed {
        logic        valid;
        logic [15:0] index;
        logic [15:0] data;
        logic        run_change;
    } sdsm_pwr_t;

    // Feedback from the motion core
    typedef struct packed {
        logic init_done;
        logic failure;
        logic stop_done;
        logic fault_stop_done;
    } sdsm_core_t;

endpackage

// [hw/sdsm_ctrl.sv]
// Drive device-control state machine with quick-stop method register.
// Assumes all inputs come from logic on ref_clk; motion core executes the stops.
`timescale 1ns/1ps

// Function
// - Clearing quick-stop bit while running starts quick stop, except command 0x0000 (switch on disabled)
// - Quick-stop method register, 16 bit, 0..7, default 2
// - Method latched on entering quick stop state
// - Start state entered on power-up or reset
// - Not ready: self-test until initialization done
// - Switch on disabled after init/fault clear; writable
// - Ready to switch on: ready, parameters writable
// - Switched on waits for enable; writable
// - Operation enabled energizes motor, runs motion
// - Running/fault reaction: only run-change writes
// - Quick stop active: stop, only run-change writes
// - Failure enters fault reaction, then fault
// - Fault disables drive, parameters writable
// - Command 0x0002 gives quick stop, status 0x0217
// - Methods 0..3 fall back to switch on disabled
// - Methods 5..7 hold; 0x0F returns to running
// - Fault left on bit7 rising edge only
module sdsm_ctrl
    import sdsm_pkg::*;
(
    input  wire logic                 ref_clk,
    input  wire logic                 rst,
    input  wire logic [15:0]          control_word,
    input  wire sdsm_pkg::sdsm_core_t core,
    input  wire sdsm_pkg::sdsm_pwr_t  param_wr,
    output logic                      param_wr_accept,
    output logic                      param_wr_reject,
    output logic [15:0]               qs_method,
    output logic [15:0]               status_word,
    output logic                      motor_energize,
    output logic                      motion_enable,
    output logic                      quick_stop_run,
    output logic [2:0]                quick_stop_mode,
    output logic                      fault_stop_run
);
    import sdsm_pkg::*;

    // ------------------------------------------------------------
    // State and registers
    // ------------------------------------------------------------
    sdsm_state_t state;
    sdsm_state_t next_state;
    logic        fault_bit_d;

    // ------------------------------------------------------------
    // Control word decode
    // ------------------------------------------------------------
    wire [15:0] cmd        = control_word & CW_CMD_MASK;
    wire        qs_bit     = control_word[CW_QUICK_STOP_BIT];
    wire        rst_bit    = control_word[CW_FAULT_RESET_BIT];
    wire        rst_rise   = rst_bit && !fault_bit_d;
    // While bit7 is held, every other command is ignored
    wire        cmd_ok     = !rst_bit;
    // Method 4 undefined: run as default method; 5..7 hold in quick stop
    wire [2:0]  method_eff = (qs_method[2:0] == 3'h4) ? QS_METHOD_RESET[2:0] : qs_method[2:0];
    wire        hold_mode  = quick_stop_mode[2];

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb
    begin
        next_state = state;
        case (state)
            ST_START:    next_state = ST_NOT_RDY;
            ST_NOT_RDY:
            begin
                if (core.failure)
                    next_state = ST_FLT_REAC;
                else if (core.init_done)
                    next_state = ST_SW_DIS;
            end
            ST_SW_DIS:
            begin
                if (cmd_ok && cmd == CW_SHUTDOWN)
                    next_state = ST_RDY;
            end
            ST_RDY:
            begin
                if (cmd_ok && cmd == CW_SWITCH_ON)
                    next_state = ST_SW_ON;
                else if (cmd_ok && cmd == CW_DISABLE)
                    next_state = ST_SW_DIS;
            end
            ST_SW_ON:
            begin
                if (cmd_ok && cmd == CW_ENABLE_OP)
                    next_state = ST_OP_EN;
                else if (cmd_ok && cmd == CW_SHUTDOWN)
                    next_state = ST_RDY;
                else if (cmd_ok && cmd == CW_DISABLE)
                    next_state = ST_SW_DIS;
            end
            ST_OP_EN:
            begin
                if (cmd_ok && cmd == CW_SWITCH_ON)
                    next_state = ST_SW_ON;
                else if (cmd_ok && cmd == CW_SHUTDOWN)
                    next_state = ST_RDY;
                else if (cmd_ok && cmd == CW_DISABLE)
                    next_state = ST_SW_DIS;
                else if (cmd_ok && !qs_bit)
                    next_state = ST_QSTOP;
            end
            ST_QSTOP:
            begin
                if (core.stop_done && !hold_mode)
                    next_state = ST_SW_DIS;
                else if (core.stop_done && hold_mode && cmd_ok && cmd == CW_ENABLE_OP)
                    next_state = ST_OP_EN;
            end
            ST_FLT_REAC:
            begin
                if (core.fault_stop_done)
                    next_state = ST_FAULT;
            end
            ST_FAULT:
            begin
                if (rst_rise)
                    next_state = ST_SW_DIS;
            end
            default:     next_state = ST_START;
        endcase
        // Any failure outside fault handling forces fault reaction
        // Start lasts one cycle only, so a failure there is seen again in not ready
        if (core.failure && state != ST_FAULT && state != ST_FLT_REAC && state != ST_START)
            next_state = ST_FLT_REAC;
    end

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            state <= ST_START;
        else
            state <= next_state;
    end

    // Bit7 history is kept in every state, so a bit held high across a fault
    // entry is not taken as a fresh reset edge
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            fault_bit_d <= 1'b0;
        else
            fault_bit_d <= rst_bit;
    end

    // ------------------------------------------------------------
    // Parameter writes
    // ------------------------------------------------------------
    // Running-type states restrict writes to run-change parameters
    wire running_state = (state == ST_OP_EN) || (state == ST_FLT_REAC) || (state == ST_QSTOP);
    wire locked_state  = (state == ST_START) || (state == ST_NOT_RDY);
    wire wr_allowed    = !locked_state && (!running_state || param_wr.run_change);
    wire wr_is_qs      = param_wr.index == QS_METHOD_OFFSET;
    // Out-of-range method values are refused rather than truncated
    wire wr_range_ok   = !wr_is_qs || (param_wr.data <= QS_METHOD_MAX);
    wire wr_ok         = param_wr.valid && wr_allowed && wr_range_ok;

    // Accept and reject are combinational so the master sees them in the strobe cycle
    assign param_wr_accept = wr_ok;
    assign param_wr_reject = param_wr.valid && !wr_ok;

    // Only the method register is stored here; other indices live outside
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            qs_method <= QS_METHOD_RESET;
        else if (wr_ok && wr_is_qs)
            qs_method <= param_wr.data;
    end

    // Method captured on entry so later writes cannot change a stop in progress
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            quick_stop_mode <= QS_METHOD_RESET[2:0];
        else if (state == ST_OP_EN && next_state == ST_QSTOP)
            quick_stop_mode <= method_eff;
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    // Outputs follow next_state so they change at the same edge as the state;
    // a deeper decode path is traded for outputs that never lag by a cycle
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            status_word    <= SW_START;
            motor_energize <= 1'b0;
            motion_enable  <= 1'b0;
            quick_stop_run <= 1'b0;
            fault_stop_run <= 1'b0;
        end
        else
        begin
            motor_energize <= next_state == ST_OP_EN || next_state == ST_QSTOP;
            motion_enable  <= next_state == ST_OP_EN;
            quick_stop_run <= next_state == ST_QSTOP;
            fault_stop_run <= next_state == ST_FLT_REAC;
            case (next_state)
                ST_START:    status_word <= SW_START;
                ST_NOT_RDY:  status_word <= SW_START;
                ST_SW_DIS:   status_word <= SW_NO_FAULT;
                ST_RDY:      status_word <= SW_READY;
                ST_SW_ON:    status_word <= SW_SWITCHED;
                ST_OP_EN:    status_word <= SW_OP_ENABLED;
                ST_QSTOP:    status_word <= SW_QUICK_STOP;
                ST_FLT_REAC: status_word <= SW_FAULT_REAC;
                ST_FAULT:    status_word <= SW_FAULT;
                default:     status_word <= SW_START;
            endcase
        end
    end

endmodule

// [testbench/sdsm_core_model.sv]
// Behavioural motion core that answers the drive state machine.
// Assumes ref_clk and rst are those of the design; the bench raises fail_req.
`timescale 1ns/1ps
module sdsm_core_model
    import sdsm_pkg::*;
#(
    parameter int STOP_CYC = 3
)
(
    input  wire logic ref_clk,
    input  wire logic rst,
    input  wire logic quick_stop_run,
    input  wire logic fault_stop_run,
    input  wire logic fail_req,
    output sdsm_pkg::sdsm_core_t core
);
    logic [3:0] init_cnt;
    logic [3:0] qs_cnt;
    logic [3:0] fs_cnt;
    // Counters saturate so a long hold never wraps back to busy
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            init_cnt <= '0;
            qs_cnt   <= '0;
            fs_cnt   <= '0;
        end
        else
        begin
            init_cnt <= init_cnt + 4'((init_cnt != 4'hf));
            qs_cnt   <= quick_stop_run ? qs_cnt + 4'((qs_cnt != 4'hf)) : '0;
            fs_cnt   <= fault_stop_run ? fs_cnt + 4'((fs_cnt != 4'hf)) : '0;
        end
    end
    // One assignment drives the whole struct, so the port has a single driver
    assign core = '{init_done:       (init_cnt >= 4'h4),
                    failure:         fail_req,
                    stop_done:       (qs_cnt >= 4'(STOP_CYC)),
                    fault_stop_done: (fs_cnt >= 4'(STOP_CYC))};
endmodule

// [testbench/sdsm_ctrl_properties.sv]
// Concurrent checks on the drive state machine ports.
// Assumes binding to sdsm_ctrl; one clock domain.
`timescale 1ns/1ps
module sdsm_ctrl_chk
    import sdsm_pkg::*;
(
    input wire logic                 ref_clk,
    input wire logic                 rst,
    input wire logic [15:0]          control_word,
    input wire sdsm_pkg::sdsm_core_t core,
    input wire sdsm_pkg::sdsm_pwr_t  param_wr,
    input wire logic                 param_wr_accept,
    input wire logic                 param_wr_reject,
    input wire logic [15:0]          qs_method,
    input wire logic [15:0]          status_word,
    input wire logic                 motor_energize,
    input wire logic                 motion_enable,
    input wire logic                 quick_stop_run,
    input wire logic [2:0]           quick_stop_mode,
    input wire logic                 fault_stop_run
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    a_qs_entry: assert property (status_word == SW_OP_ENABLED && control_word == CW_QUICK_STOP
        && !core.failure |=> status_word == SW_QUICK_STOP) else $error("quick stop not entered");
    a_mode_latch: assert property ($rose(quick_stop_run) |-> quick_stop_mode ==
        ($past(qs_method[2:0]) == 3'h4 ? 3'h2 : $past(qs_method[2:0]))) else $error("bad stop mode");
    a_method_range: assert property (qs_method <= QS_METHOD_MAX) else $error("method out of range");
    a_run_lock: assert property (param_wr.valid && motion_enable && !param_wr.run_change
        |-> param_wr_reject) else $error("locked write taken");
    a_fault_write: assert property (param_wr.valid && status_word == SW_FAULT
        && param_wr.index != QS_METHOD_OFFSET |-> param_wr_accept) else $error("fault write refused");
    a_energize_op: assert property (motion_enable |-> motor_energize
        && status_word == SW_OP_ENABLED) else $error("motion without power");
    a_fault_seq: assert property (fault_stop_run && core.fault_stop_done && !core.failure
        |=> status_word == SW_FAULT) else $error("fault not reached");
    a_fault_exit: assert property (status_word == SW_FAULT && !$rose(control_word[7])
        |=> status_word == SW_FAULT) else $error("fault left early");
    a_auto_return: assert property (quick_stop_run && core.stop_done && quick_stop_mode <= 3'h3
        && !core.failure |=> status_word == SW_NO_FAULT) else $error("no return after stop");
    c_quick_stop: cover property ($rose(quick_stop_run));
    c_fault: cover property (status_word == SW_FAULT);
    c_reject: cover property (param_wr_reject);
endmodule

// [testbench/tb.sv]
// Self-checking bench for the drive state machine.
// Assumes the core model answers stops after a few cycles.
`timescale 1ns/1ps
module tb;
    import sdsm_pkg::*;
    logic        ref_clk = 0, rst = 1, fail_req = 0;
    logic [15:0] control_word = '0;
    sdsm_pwr_t   param_wr = '0;
    sdsm_core_t  core;
    logic        acc, rej, mot, mov, qsr, fsr;
    logic [15:0] qsm, sw;
    logic [2:0]  qmode;
    int          fail_count = 0, check_count = 0;
    logic [15:0] ms [7] = '{16'h0, 16'h1, 16'h2, 16'h3, 16'h4, 16'h6, 16'h7};
    sdsm_ctrl u_dut (.ref_clk(ref_clk), .rst(rst), .control_word(control_word), .core(core),
        .param_wr(param_wr), .param_wr_accept(acc), .param_wr_reject(rej), .qs_method(qsm),
        .status_word(sw), .motor_energize(mot), .motion_enable(mov), .quick_stop_run(qsr),
        .quick_stop_mode(qmode), .fault_stop_run(fsr));
    sdsm_core_model u_core (.ref_clk(ref_clk), .rst(rst), .quick_stop_run(qsr),
        .fault_stop_run(fsr), .fail_req(fail_req), .core(core));
    initial forever #2 ref_clk = ~ref_clk;
    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        check_count++;
        if (g !== e)
        begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic cmd(input logic [15:0] cw, input logic [15:0] e);
        @(posedge ref_clk);
        control_word <= cw;
        @(posedge ref_clk);
        #1 chk("status", e, sw);
    endtask
    task automatic wr(input logic [15:0] i, input logic [15:0] d, input logic rc, input logic ok);
        @(posedge ref_clk);
        param_wr <= '{1'b1, i, d, rc};
        #1 chk("accept", {15'h0, ok}, {15'h0, acc});
        chk("reject", {15'h0, !ok}, {15'h0, rej});
        @(posedge ref_clk);
        param_wr.valid <= 1'b0;
        #1;
    endtask
    task automatic wait_sw(input logic [15:0] e);
        for (int i = 0; i < 20 && sw !== e; i++)
            @(posedge ref_clk) #1;
        chk("status", e, sw);
    endtask
    task automatic to_op();
        cmd(16'h0006, SW_READY);
        cmd(16'h0007, SW_SWITCHED);
        cmd(16'h000f, SW_OP_ENABLED);
    endtask
    task automatic close_out();
        if (fail_count == 0 && check_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    initial
    begin
        repeat (2) @(posedge ref_clk);
        #1 chk("reset status", SW_START, sw);
        @(posedge ref_clk);
        rst <= 1'b0;
        wait_sw(SW_NO_FAULT);
        chk("method", QS_METHOD_RESET, qsm);
        wr(QS_METHOD_OFFSET, 16'h8, 1'b0, 1'b0);
        wr(QS_METHOD_OFFSET, 16'h5, 1'b0, 1'b1);
        chk("method", 16'h5, qsm);
        cmd(16'h0006, SW_READY);
        wr(16'h1000, 16'h1, 1'b0, 1'b1);
        cmd(16'h0007, SW_SWITCHED);
        wr(16'h1000, 16'h2, 1'b0, 1'b1);
        cmd(16'h000f, SW_OP_ENABLED);
        chk("motion", 16'h1, {15'h0, mov});
        wr(16'h1000, 16'h3, 1'b0, 1'b0);
        wr(16'h1000, 16'h3, 1'b1, 1'b1);
        cmd(CW_QUICK_STOP, SW_QUICK_STOP);
        chk("mode", 16'h5, {13'h0, qmode});
        chk("stop run", 16'h1, {15'h0, qsr});
        chk("energize", 16'h1, {15'h0, mot});
        wr(QS_METHOD_OFFSET, 16'h1, 1'b0, 1'b0);
        repeat (8) @(posedge ref_clk);
        #1 chk("status", SW_QUICK_STOP, sw);
        cmd(16'h000f, SW_OP_ENABLED);
        cmd(16'h0000, SW_NO_FAULT);
        // Methods 0..4, 6 and 7 each from its own run, so the latch sees a fresh value
        foreach (ms[k])
        begin
            wr(QS_METHOD_OFFSET, ms[k], 1'b0, 1'b1);
            to_op();
            cmd(CW_QUICK_STOP, SW_QUICK_STOP);
            chk("mode", (ms[k] == 16'h4) ? 16'h2 : ms[k], {13'h0, qmode});
            if (ms[k] <= 16'h4)
                wait_sw(SW_NO_FAULT);
            else
            begin
                repeat (4) @(posedge ref_clk);
                #1 chk("status", SW_QUICK_STOP, sw);
                cmd(16'h000f, SW_OP_ENABLED);
                cmd(16'h0000, SW_NO_FAULT);
            end
        end
        to_op();
        @(posedge ref_clk);
        fail_req <= 1'b1;
        @(posedge ref_clk);
        fail_req <= 1'b0;
        #1 chk("status", SW_FAULT_REAC, sw);
        chk("fault run", 16'h1, {15'h0, fsr});
        wait_sw(SW_FAULT);
        chk("energize", 16'h0, {15'h0, mot});
        wr(16'h1000, 16'h4, 1'b0, 1'b1);
        cmd(16'h0006, SW_FAULT);
        cmd(16'h0080, SW_NO_FAULT);
        cmd(16'h0086, SW_NO_FAULT);
        @(posedge ref_clk);
        rst <= 1'b1;
        @(posedge ref_clk);
        #1 chk("reset status", SW_START, sw);
        chk("method", QS_METHOD_RESET, qsm);
        chk("mode", 16'h2, {13'h0, qmode});
        @(posedge ref_clk);
        rst <= 1'b0;
        control_word <= '0;
        wait_sw(SW_NO_FAULT);
        close_out();
    end
    initial
    begin
        repeat (5000) @(posedge ref_clk);
        fail_count++;
        close_out();
    end
endmodule
bind sdsm_ctrl sdsm_ctrl_chk u_chk (.ref_clk(ref_clk), .rst(rst), .control_word(control_word),
    .core(core), .param_wr(param_wr), .param_wr_accept(param_wr_accept),
    .param_wr_reject(param_wr_reject), .qs_method(qs_method), .status_word(status_word),
    .motor_energize(motor_energize), .motion_enable(motion_enable), .quick_stop_run(quick_stop_run),
    .quick_stop_mode(quick_stop_mode), .fault_stop_run(fault_stop_run));
